// ### rtcsr_app_model.sv
/*
 * Application-side model that stages a date/time, sets select flags and
 * pulses the write strobe once per request.
 * Assumes it is called just after a rising edge of clk_sys.
 */
module rtcsr_app_model (
    input wire logic clk_sys,
    output logic [41:0] prog_t,
    output logic [5:0] sel_t,
    output logic ctl_write
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        prog_t = 42'h0;
        sel_t = 6'h0;
        ctl_write = 1'b0;
    end
    task automatic write_time(input logic [41:0] t, input logic [5:0] sel, input int gap,
        input int hold);
        prog_t = t; // Staged with strobe low
        sel_t = sel; // Select flags, year first
        repeat (gap + 1)
        begin
            @(posedge clk_sys);
            #1;
        end
        ctl_write = 1'b1; // Rising edge requests the update
        @(posedge clk_sys);
        #1;
        repeat (hold)
        begin
            prog_t = ~t; // Strobe still high, must not load
            @(posedge clk_sys);
            #1;
        end
        ctl_write = 1'b0;
    endtask : write_time
endmodule : rtcsr_app_model

// ### rtcsr_ctrl.sv
/*
 * Real-time clock with staged set fields, edge-triggered write, per-field
 * select, calendar check and per-cycle snapshot refresh.
 * Assumes all control inputs are synchronous to clk_sys; one clock is one scan cycle.
 */
// Function
// R1: Six staged fields never change the clock on their own.
// R2: Update only on FALSE-to-TRUE change of the write strobe.
// R3: On update copy only fields whose select flag is TRUE.
// R4: Unselected clock fields keep their current value during an update.
// R5: Commit only a valid calendar result; otherwise raise a run-time error.
// R6: Snapshot refreshes each cycle while read enable TRUE; stops when FALSE.
// R7: Points: 1 write, 2 read, 3-8 select year..seconds.
// R8: Snapshot shows year, month, day, hours, minutes, seconds each cycle.
// R9: Edge found against last cycle's strobe; rejected update changes nothing.
module rtcsr_ctrl #(
    parameter int unsigned TICK_CYCLES = rtcsr_pkg::TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [rtcsr_pkg::YEAR_W-1:0] prog_year,
    input wire logic [rtcsr_pkg::MON_W-1:0] prog_mon,
    input wire logic [rtcsr_pkg::DAY_W-1:0] prog_day,
    input wire logic [rtcsr_pkg::HOUR_W-1:0] prog_hour,
    input wire logic [rtcsr_pkg::MIN_W-1:0] prog_min,
    input wire logic [rtcsr_pkg::SEC_W-1:0] prog_sec,
    input wire logic ctl_write,
    input wire logic ctl_read,
    input wire logic set_year,
    input wire logic set_mon,
    input wire logic set_day,
    input wire logic set_hour,
    input wire logic set_min,
    input wire logic set_sec,
    output logic [rtcsr_pkg::YEAR_W-1:0] snap_year_reg,
    output logic [rtcsr_pkg::MON_W-1:0] snap_mon_reg,
    output logic [rtcsr_pkg::DAY_W-1:0] snap_day_reg,
    output logic [rtcsr_pkg::HOUR_W-1:0] snap_hour_reg,
    output logic [rtcsr_pkg::MIN_W-1:0] snap_min_reg,
    output logic [rtcsr_pkg::SEC_W-1:0] snap_sec_reg,
    output logic rtc_err_reg
);
    import rtcsr_pkg::*;

    function automatic logic [DAY_W-1:0] days_in_month(
        input logic [YEAR_W-1:0] y,
        input logic [MON_W-1:0] m
    );
        logic leap;
        leap = ((y % 16'h0004) == 16'h0000 && (y % 16'h0064) != 16'h0000)
            || ((y % 16'h0190) == 16'h0000);
        if (m == MON_FEB)
            days_in_month = leap ? 5'h1d : 5'h1c;
        else if (m == 4'h4 || m == 4'h6 || m == 4'h9 || m == 4'hb)
            days_in_month = 5'h1e;
        else
            days_in_month = 5'h1f;
    endfunction : days_in_month

    function automatic logic date_valid(
        input logic [YEAR_W-1:0] y,
        input logic [MON_W-1:0] m,
        input logic [DAY_W-1:0] d,
        input logic [HOUR_W-1:0] h,
        input logic [MIN_W-1:0] mi,
        input logic [SEC_W-1:0] s
    );
        date_valid = (y <= YEAR_MAX) && (m != 4'h0) && (m <= MON_MAX)
            && (d != 5'h00) && (d <= days_in_month(y, m))
            && (h <= HOUR_MAX) && (mi <= MIN_MAX) && (s <= SEC_MAX);
    endfunction : date_valid

    logic [YEAR_W-1:0] rtc_year_reg;
    logic [MON_W-1:0] rtc_mon_reg;
    logic [DAY_W-1:0] rtc_day_reg;
    logic [HOUR_W-1:0] rtc_hour_reg;
    logic [MIN_W-1:0] rtc_min_reg;
    logic [SEC_W-1:0] rtc_sec_reg;
    logic [YEAR_W-1:0] year_next, cand_year;
    logic [MON_W-1:0] mon_next, cand_mon;
    logic [DAY_W-1:0] day_next, cand_day;
    logic [HOUR_W-1:0] hour_next, cand_hour;
    logic [MIN_W-1:0] min_next, cand_min;
    logic [SEC_W-1:0] sec_next, cand_sec;
    logic [PRE_W-1:0] pre_reg;
    logic write_prev_reg;
    logic write_edge, cand_ok, commit, tick_now;

    // Strobe edge against last cycle's strobe
    assign write_edge = ctl_write && !write_prev_reg; // [R2] [R9]
    assign tick_now = (pre_reg == PRE_W'(TICK_CYCLES - 1));

    // Candidate: selected staged fields over current clock
    always_comb
    begin
        cand_year = set_year ? prog_year : rtc_year_reg; // [R3] [R4] [R7]
        cand_mon = set_mon ? prog_mon : rtc_mon_reg; // [R3] [R4] [R7]
        cand_day = set_day ? prog_day : rtc_day_reg; // [R3] [R4] [R7]
        cand_hour = set_hour ? prog_hour : rtc_hour_reg; // [R3] [R4] [R7]
        cand_min = set_min ? prog_min : rtc_min_reg; // [R3] [R4] [R7]
        cand_sec = set_sec ? prog_sec : rtc_sec_reg; // [R3] [R4] [R7]
    end

    assign cand_ok = date_valid(cand_year, cand_mon, cand_day, cand_hour, cand_min,
        cand_sec); // [R5]
    assign commit = write_edge && cand_ok; // [R5] [R9]

    // One-second advance with calendar rollover
    always_comb
    begin
        year_next = rtc_year_reg;
        mon_next = rtc_mon_reg;
        day_next = rtc_day_reg;
        hour_next = rtc_hour_reg;
        min_next = rtc_min_reg;
        sec_next = rtc_sec_reg + 6'h01;
        if (rtc_sec_reg >= SEC_MAX)
        begin
            sec_next = 6'h00;
            min_next = rtc_min_reg + 6'h01;
            if (rtc_min_reg >= MIN_MAX)
            begin
                min_next = 6'h00;
                hour_next = rtc_hour_reg + 5'h01;
                if (rtc_hour_reg >= HOUR_MAX)
                begin
                    hour_next = 5'h00;
                    day_next = rtc_day_reg + 5'h01;
                    if (rtc_day_reg >= days_in_month(rtc_year_reg, rtc_mon_reg))
                    begin
                        day_next = 5'h01;
                        mon_next = rtc_mon_reg + 4'h1;
                        if (rtc_mon_reg >= MON_MAX)
                        begin
                            mon_next = 4'h1;
                            year_next = (rtc_year_reg >= YEAR_MAX) ? 16'h0000
                                : rtc_year_reg + 16'h0001;
                        end
                    end
                end
            end
        end
    end

    // Strobe history
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            write_prev_reg <= 1'b0;
        else
            write_prev_reg <= ctl_write; // [R9]
    end

    // Second prescaler, restarted by a committed write
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            pre_reg <= '0;
        else if (commit || tick_now)
            pre_reg <= '0;
        else
            pre_reg <= pre_reg + 27'h0000001;
    end

    // Clock fields: committed write wins over the tick
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rtc_year_reg <= RST_YEAR;
            rtc_mon_reg <= RST_MON;
            rtc_day_reg <= RST_DAY;
            rtc_hour_reg <= RST_HOUR;
            rtc_min_reg <= RST_MIN;
            rtc_sec_reg <= RST_SEC;
        end
        else if (commit) // [R1] [R2] [R5]
        begin
            rtc_year_reg <= cand_year;
            rtc_mon_reg <= cand_mon;
            rtc_day_reg <= cand_day;
            rtc_hour_reg <= cand_hour;
            rtc_min_reg <= cand_min;
            rtc_sec_reg <= cand_sec;
        end
        else if (tick_now)
        begin
            rtc_year_reg <= year_next;
            rtc_mon_reg <= mon_next;
            rtc_day_reg <= day_next;
            rtc_hour_reg <= hour_next;
            rtc_min_reg <= min_next;
            rtc_sec_reg <= sec_next;
        end
    end

    // Run-time error pulse on a rejected write
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            rtc_err_reg <= 1'b0;
        else
            rtc_err_reg <= write_edge && !cand_ok; // [R5]
    end

    // Snapshot refresh
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            snap_year_reg <= RST_YEAR;
            snap_mon_reg <= RST_MON;
            snap_day_reg <= RST_DAY;
            snap_hour_reg <= RST_HOUR;
            snap_min_reg <= RST_MIN;
            snap_sec_reg <= RST_SEC;
        end
        else if (ctl_read) // [R6] [R8]
        begin
            snap_year_reg <= rtc_year_reg;
            snap_mon_reg <= rtc_mon_reg;
            snap_day_reg <= rtc_day_reg;
            snap_hour_reg <= rtc_hour_reg;
            snap_min_reg <= rtc_min_reg;
            snap_sec_reg <= rtc_sec_reg;
        end
    end

    // Checks
    logic [41:0] clk_all, snap_all;
    assign clk_all = {rtc_year_reg, rtc_mon_reg, rtc_day_reg, rtc_hour_reg, rtc_min_reg,
        rtc_sec_reg};
    assign snap_all = {snap_year_reg, snap_mon_reg, snap_day_reg, snap_hour_reg,
        snap_min_reg, snap_sec_reg};

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    property p_stage_only;
        (!write_edge && !tick_now) |=> $stable(clk_all);
    endproperty
    a_stage_only: assert property (p_stage_only) else $error("Clock moved without write"); // [R1]

    property p_level_no_err;
        (ctl_write && $past(ctl_write)) |=> !rtc_err_reg;
    endproperty
    a_level_no_err: assert property (p_level_no_err) else $error("Error on held strobe"); // [R2]

    property p_sel_sec;
        (write_edge && cand_ok && set_sec) |=> (rtc_sec_reg == $past(prog_sec));
    endproperty
    a_sel_sec: assert property (p_sel_sec) else $error("Selected seconds not loaded"); // [R3]

    property p_unsel_min;
        (commit && !set_min) |=> (rtc_min_reg == $past(rtc_min_reg));
    endproperty
    a_unsel_min: assert property (p_unsel_min) else $error("Unselected minutes changed"); // [R4]

    property p_bad_err;
        (write_edge && !cand_ok) |=> rtc_err_reg ##1 !rtc_err_reg;
    endproperty
    a_bad_err: assert property (p_bad_err) else $error("Invalid write not flagged"); // [R5]

    property p_read_off;
        !ctl_read |=> $stable(snap_all);
    endproperty
    a_read_off: assert property (p_read_off) else $error("Snapshot moved while disabled"); // [R6]

    property p_sel_year;
        (commit && set_year) |=> (rtc_year_reg == $past(prog_year));
    endproperty
    a_sel_year: assert property (p_sel_year) else $error("Year flag not mapped"); // [R7]

    property p_refresh;
        ctl_read |=> (snap_all == $past(clk_all));
    endproperty
    a_refresh: assert property (p_refresh) else $error("Snapshot not refreshed"); // [R8]

    property p_reject_hold;
        (write_edge && !cand_ok && !tick_now) |=> $stable(clk_all) && rtc_err_reg;
    endproperty
    a_reject_hold: assert property (p_reject_hold) else $error("Rejected write changed clock"); // [R9]

    property p_always_valid;
        date_valid(rtc_year_reg, rtc_mon_reg, rtc_day_reg, rtc_hour_reg, rtc_min_reg,
            rtc_sec_reg);
    endproperty
    a_always_valid: assert property (p_always_valid) else $error("Clock holds bad date"); // [R5]

    c_commit: cover property (commit ##1 ctl_read);
    c_reject: cover property (write_edge && !cand_ok);
    c_tick: cover property (tick_now && rtc_sec_reg == SEC_MAX);
    c_read_stop: cover property (ctl_read ##1 !ctl_read);
endmodule : rtcsr_ctrl

// ### rtcsr_pkg.sv
/*
 * Shared constants for the clock set/refresh control block: field widths,
 * calendar limits, reset date and time, and the one-second tick timing.
 * Assumes a 100 MHz system clock with one scan cycle per clock edge.
 */
package rtcsr_pkg;
    localparam int unsigned YEAR_W = 16;
    localparam int unsigned MON_W = 4;
    localparam int unsigned DAY_W = 5;
    localparam int unsigned HOUR_W = 5;
    localparam int unsigned MIN_W = 6;
    localparam int unsigned SEC_W = 6;
    localparam int unsigned PRE_W = 27;

    localparam logic [YEAR_W-1:0] YEAR_MAX = 16'h270f;
    localparam logic [MON_W-1:0] MON_MAX = 4'hc;
    localparam logic [HOUR_W-1:0] HOUR_MAX = 5'h17;
    localparam logic [MIN_W-1:0] MIN_MAX = 6'h3b;
    localparam logic [SEC_W-1:0] SEC_MAX = 6'h3b;
    localparam logic [MON_W-1:0] MON_FEB = 4'h2;

    localparam logic [YEAR_W-1:0] RST_YEAR = 16'h07d0;
    localparam logic [MON_W-1:0] RST_MON = 4'h1;
    localparam logic [DAY_W-1:0] RST_DAY = 5'h01;
    localparam logic [HOUR_W-1:0] RST_HOUR = 5'h00;
    localparam logic [MIN_W-1:0] RST_MIN = 6'h00;
    localparam logic [SEC_W-1:0] RST_SEC = 6'h00;

    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SECOND_NS = 1000000000;
    localparam int unsigned TICK_CYCLES = SECOND_NS / CLK_PERIOD_NS;
endpackage : rtcsr_pkg

// ### tb_rtcsr_set_refresh_control.sv
/*
 * Self-checking bench: drives writes and reads, queues expected results.
 * Assumes the prescaler never completes a second within the run.
 */
module tb_rtc_set_refresh_control;
    timeunit 1ns;
    timeprecision 100ps;
    import rtcsr_pkg::*;
    localparam int TICKS = 1000000;
    typedef struct {int due; bit is_err; logic [41:0] val;} rtcsr_exp_t;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic ctl_read = 1'b1;
    logic exp_err;
    logic [41:0] clk_m, snap_m;
    wire [41:0] prog_t, snap_t;
    wire [5:0] sel_t;
    wire ctl_write, rtc_err_reg;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    integer seed = 32'h48a5;
    rtcsr_exp_t exp_q[$];
    int by[7] = '{2000, 2100, 2024, 2023, 2023, 9999, 10000};
    int bm[7] = '{2, 2, 2, 4, 12, 12, 1};
    int bd[7] = '{29, 29, 29, 31, 31, 31, 1};
    always #5 clk_sys = ~clk_sys;
    rtcsr_app_model app_u (.clk_sys(clk_sys), .prog_t(prog_t), .sel_t(sel_t),
        .ctl_write(ctl_write));
    rtcsr_ctrl #(.TICK_CYCLES(TICKS)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
        .prog_year(prog_t[41:26]), .prog_mon(prog_t[25:22]), .prog_day(prog_t[21:17]),
        .prog_hour(prog_t[16:12]), .prog_min(prog_t[11:6]), .prog_sec(prog_t[5:0]),
        .ctl_write(ctl_write), .ctl_read(ctl_read), .set_year(sel_t[5]),
        .set_mon(sel_t[4]), .set_day(sel_t[3]), .set_hour(sel_t[2]),
        .set_min(sel_t[1]), .set_sec(sel_t[0]),
        .snap_year_reg(snap_t[41:26]), .snap_mon_reg(snap_t[25:22]),
        .snap_day_reg(snap_t[21:17]), .snap_hour_reg(snap_t[16:12]),
        .snap_min_reg(snap_t[11:6]), .snap_sec_reg(snap_t[5:0]), .rtc_err_reg(rtc_err_reg));
    function automatic logic [41:0] mk(int y, int m, int d, int h, int mi, int s);
        return {16'(y), 4'(m), 5'(d), 5'(h), 6'(mi), 6'(s)};
    endfunction : mk
    function automatic bit ok_time(logic [41:0] t);
        int y, m, d, md;
        y = t[41:26];
        m = t[25:22];
        d = t[21:17];
        md = (m == 4 || m == 6 || m == 9 || m == 11) ? 30 : 31;
        if (m == 2)
            md = (y % 4 == 0 && (y % 100 != 0 || y % 400 == 0)) ? 29 : 28;
        return y <= 9999 && m >= 1 && m <= 12 && d >= 1 && d <= md && t[16:12] < 24
            && t[11:6] < 60 && t[5:0] < 60;
    endfunction : ok_time
    task automatic cmp_snap(logic [41:0] got, logic [41:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t snapshot got %h exp %h", $time, got, exp);
        end
    endtask : cmp_snap
    task automatic cmp_err(logic got, logic exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t error flag got %h exp %h", $time, got, exp);
        end
    endtask : cmp_err
    task complete_run;
        if (miscompares == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    task automatic do_write(logic [41:0] t, logic [5:0] sel, int gap, int hold);
        logic [41:0] msk, c;
        bit ok;
        msk = {{16{sel[5]}}, {4{sel[4]}}, {5{sel[3]}}, {5{sel[2]}}, {6{sel[1]}}, {6{sel[0]}}};
        c = (t & msk) | (clk_m & ~msk); // Only selected fields replace the clock
        ok = ok_time(c);
        if (ok)
            clk_m = c; // Invalid result leaves the clock untouched
        if (ctl_read)
            snap_m = clk_m;
        exp_q.push_back('{cyc + gap + 2, 1'b1, {41'h0, !ok}});
        exp_q.push_back('{cyc + gap + 3, 1'b0, snap_m});
        app_u.write_time(t, sel, gap, hold);
    endtask : do_write
    always @(posedge clk_sys)
    begin
        cyc++;
        #2;
        exp_err = 1'b0;
        while (exp_q.size() > 0 && exp_q[0].due == cyc)
        begin
            if (exp_q[0].is_err)
                exp_err = exp_q[0].val[0];
            else
                cmp_snap(snap_t, exp_q[0].val);
            void'(exp_q.pop_front());
        end
        cmp_err(rtc_err_reg, exp_err);
    end
    initial
    begin
        repeat (50000) @(posedge clk_sys);
        miscompares++;
        complete_run();
    end
    initial
    begin
        clk_m = {RST_YEAR, RST_MON, RST_DAY, RST_HOUR, RST_MIN, RST_SEC};
        snap_m = clk_m;
        repeat (8) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        exp_q.push_back('{cyc + 1, 1'b0, snap_m});
        for (int i = 0; i < 6; i++)
            do_write(mk(2001 + i, 3 + i, 5 + i, 7 + i, 9 + i, 11 + i), 6'h1 << i, i % 2, 0);
        for (int i = 0; i < 7; i++)
            do_write(mk(by[i], bm[i], bd[i], 23, 59, 59), 6'h3f, 0, 0);
        do_write(mk(2030, 6, 15, 12, 30, 45), 6'h3f, 1, 3);
        repeat (20)
            do_write(mk({$random(seed)} % 10100, $random(seed), $random(seed), $random(seed),
                $random(seed), $random(seed)), 6'($random(seed)), {$random(seed)} % 3,
                {$random(seed)} % 2);
        @(posedge clk_sys);
        #1;
        ctl_read = 1'b0;
        do_write(mk(2044, 8, 8, 8, 8, 8), 6'h3f, 1, 0);
        do_write(mk(2045, 9, 9, 9, 9, 9), 6'h3f, 0, 0);
        @(posedge clk_sys);
        #1;
        ctl_read = 1'b1;
        snap_m = clk_m;
        exp_q.push_back('{cyc + 1, 1'b0, snap_m});
        for (int i = 0; i < 10 && exp_q.size() > 0; i++)
            @(posedge clk_sys);
        #3;
        if (exp_q.size() > 0)
            miscompares++;
        complete_run();
    end
endmodule : tb_rtc_set_refresh_control
